// *** rtl/sseq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - start while idle enters run and begins at step 1 at once
// - start after a hold control resumes exactly where the hold froze things
// - start after a termination hold restarts from that step's jump target
// - hold control enters hold, pauses stepping and freezes the output
// - stop control enters idle and switches at once to the regular step
// - stop copies the present output values into the regular step
// - branch goes to the step's branch target from the present output
// - loops come from each step's jump target and jump count
// - every step has its own jump counter
// - jump count n from 1 jumps n times, the block runs n plus 1 times; count 0 loops without end
// - a running step drives its sync code on the sync output
// - the regular step drives the sync output all inactive
// - with end phase on, a step ends at first phase zero after its time
// - during the phase zero wait the output keeps the step's final values
// - per-step waveform change only among user waveform slots 1 to 16
// - a sine or square sequence keeps its waveform throughout
// - jump target zero means next step, 1 to 255 an explicit step
// - branch target zero leaves the current step running
// - termination hold or stop wins over a jump target at step end
module sseq_ctrl
#(
  parameter int TICK_CYCLES = sseq_pkg::TICK_CYCLES
)
(
  // clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rst_b_i,
  // sequence controls, one-cycle pulses
  input  wire logic                             start_i,
  input  wire logic                             hold_i,
  input  wire logic                             stop_i,
  input  wire logic                             branch_i,
  // configuration and waveform engine status
  input  wire logic [sseq_pkg::KIND_W-1:0]      wave_kind_i,
  input  wire logic [sseq_pkg::STEP_W-1:0]      last_step_i,
  input  wire logic                             phase_zero_i,
  // step programming port, address 0 is the regular step
  input  wire logic                             prog_we_i,
  input  wire logic [sseq_pkg::STEP_W-1:0]      prog_addr_i,
  input  wire logic [sseq_pkg::WORD_W-1:0]      prog_word_i,
  // status
  output logic      [sseq_pkg::STAT_W-1:0]      status_o,
  output logic      [sseq_pkg::STEP_W-1:0]      step_o,
  // output set values and step sync
  output logic      [sseq_pkg::VAL_W-1:0]       out_dc_o,
  output logic      [sseq_pkg::VAL_W-1:0]       out_ac_o,
  output logic      [sseq_pkg::VAL_W-1:0]       out_freq_o,
  output logic      [sseq_pkg::SLOT_W-1:0]      user_waveform_slot_o,
  output logic      [sseq_pkg::SYNC_W-1:0]      step_sync_o
);

  // ************************************************************
  // state
  // ************************************************************
  sseq_pkg::sseq_state_t              state_ff, nxt_state;
  logic [sseq_pkg::STEP_W-1:0]        step_ff, nxt_step;
  logic [sseq_pkg::WORD_W-1:0]        word_ff;
  logic [sseq_pkg::TIME_W-1:0]        timer_ff;
  logic [13:0]                        tick_ff;
  logic                               term_hold_ff;
  logic                               hold_ph_ff;
  logic [sseq_pkg::KIND_W-1:0]        kind_ff;
  logic [sseq_pkg::VAL_W-1:0]         reg_dc_ff, reg_ac_ff, reg_freq_ff;
  logic [sseq_pkg::SLOT_W-1:0]        reg_slot_ff;
  logic [sseq_pkg::VAL_W-1:0]         dc_ff, ac_ff, freq_ff;
  logic [sseq_pkg::SLOT_W-1:0]        slot_ff;
  logic [sseq_pkg::SYNC_W-1:0]        sync_ff;
  logic [sseq_pkg::WORD_W-1:0]        mem_rdata;
  logic [sseq_pkg::JCNT_W-1:0]        jc_cnt;

  // ************************************************************
  // fields of the running step
  // ************************************************************
  wire                        f_phase  = word_ff[sseq_pkg::PHASE_BIT];
  wire [sseq_pkg::TERM_W-1:0] f_term   = word_ff[sseq_pkg::TERM_LSB +: sseq_pkg::TERM_W];
  wire [sseq_pkg::STEP_W-1:0] f_jstep  = word_ff[sseq_pkg::JSTEP_LSB +: sseq_pkg::STEP_W];
  wire [sseq_pkg::JCNT_W-1:0] f_jcnt   = word_ff[sseq_pkg::JCNT_LSB +: sseq_pkg::JCNT_W];
  wire [sseq_pkg::STEP_W-1:0] f_branch = word_ff[sseq_pkg::BRANCH_LSB +: sseq_pkg::STEP_W];

  // ************************************************************
  // control decode
  // ************************************************************
  wire in_idle  = (state_ff == sseq_pkg::ST_IDLE);
  wire in_hold  = (state_ff == sseq_pkg::ST_HOLD);
  wire in_step  = (state_ff == sseq_pkg::ST_RUN) || (state_ff == sseq_pkg::ST_PHASE);
  wire in_fetch = (state_ff == sseq_pkg::ST_LOAD) || (state_ff == sseq_pkg::ST_APPLY);
  // priority stop > hold > branch > start, except that start from idle wins over stop; the rest is ignored
  wire do_stop   = stop_i && !in_idle;
  wire do_hold   = hold_i && in_step && !stop_i;
  wire do_branch = branch_i && in_step && !stop_i && !hold_i
                   && (f_branch != sseq_pkg::BRANCH_NONE);
  wire start_idle = start_i && in_idle;
  wire start_hold = start_i && in_hold && !stop_i;

  // ************************************************************
  // step end and jump decision
  // ************************************************************
  wire tick_last = (tick_ff == 14'(TICK_CYCLES - 1));
  wire time_done = (timer_ff == sseq_pkg::TIME_RST);
  wire run_ok    = !do_stop && !do_hold && !do_branch;
  wire to_phase  = (state_ff == sseq_pkg::ST_RUN) && time_done && f_phase && run_ok;
  wire step_end  = run_ok && (((state_ff == sseq_pkg::ST_RUN) && time_done && !f_phase)
                   || ((state_ff == sseq_pkg::ST_PHASE) && phase_zero_i));
  wire has_jump  = (f_jstep != sseq_pkg::JUMP_NEXT);
  wire jc_left   = (f_jcnt == sseq_pkg::JCNT_INF) || (jc_cnt < f_jcnt);
  wire do_jump   = has_jump && jc_left;
  wire past_end  = (step_ff >= last_step_i) || (step_ff == sseq_pkg::STEP_LAST);
  wire [sseq_pkg::STEP_W-1:0] step_inc = step_ff + 8'h01;
  wire end_continue_after_step  = step_end && (f_term == sseq_pkg::TERM_CONTINUE_AFTER_STEP);
  wire end_hold  = step_end && (f_term == sseq_pkg::TERM_HOLD);
  wire end_idle  = step_end && ((f_term == sseq_pkg::TERM_STOP)
                   || ((f_term == sseq_pkg::TERM_CONTINUE_AFTER_STEP) && !do_jump && past_end));
  wire go_idle   = do_stop || end_idle;
  // jump counter updates, an exhausted loop clears so a reentry counts afresh
  wire jc_inc = end_continue_after_step && do_jump && (f_jcnt != sseq_pkg::JCNT_INF);
  wire jc_clr = end_continue_after_step && has_jump && !jc_left;
  // a termination hold restarts from the jump target, or the next step
  wire [sseq_pkg::STEP_W-1:0] restart_step = has_jump ? f_jstep : step_inc;

  // ************************************************************
  // next state and step number
  // ************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    nxt_step  = step_ff;
    unique case (state_ff)
      sseq_pkg::ST_IDLE:
      begin
        if (start_idle)
        begin
          nxt_state = sseq_pkg::ST_LOAD;
          nxt_step  = sseq_pkg::STEP_FIRST;
        end
      end
      sseq_pkg::ST_LOAD:  nxt_state = sseq_pkg::ST_APPLY;
      sseq_pkg::ST_APPLY: nxt_state = sseq_pkg::ST_RUN;
      sseq_pkg::ST_RUN, sseq_pkg::ST_PHASE:
      begin
        if (do_hold)
          nxt_state = sseq_pkg::ST_HOLD;
        else if (do_branch)
        begin
          nxt_state = sseq_pkg::ST_LOAD;
          nxt_step  = f_branch;
        end
        else if (to_phase)
          nxt_state = sseq_pkg::ST_PHASE;
        else if (end_hold)
          nxt_state = sseq_pkg::ST_HOLD;
        else if (end_continue_after_step && !end_idle)
        begin
          nxt_state = sseq_pkg::ST_LOAD;
          nxt_step  = do_jump ? f_jstep : step_inc;
        end
      end
      sseq_pkg::ST_HOLD:
      begin
        if (start_hold && term_hold_ff)
        begin
          nxt_state = sseq_pkg::ST_LOAD;
          nxt_step  = restart_step;
        end
        else if (start_hold)
          nxt_state = hold_ph_ff ? sseq_pkg::ST_PHASE : sseq_pkg::ST_RUN;
      end
      default: nxt_state = sseq_pkg::ST_IDLE;
    endcase
    if (go_idle)
    begin
      nxt_state = sseq_pkg::ST_IDLE;
      nxt_step  = sseq_pkg::STEP_REGULAR;
    end
  end

  // state and step registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_ff <= sseq_pkg::ST_IDLE;
      step_ff  <= sseq_pkg::STEP_REGULAR;
    end
    else
    begin
      state_ff <= nxt_state;
      step_ff  <= nxt_step;
    end
  end

  // how hold was entered, and from which wait, decides what start does
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      term_hold_ff <= 1'b0;
      hold_ph_ff   <= 1'b0;
    end
    else if (do_hold || end_hold)
    begin
      term_hold_ff <= end_hold && !do_hold;
      hold_ph_ff   <= (state_ff == sseq_pkg::ST_PHASE);
    end
  end

  // ************************************************************
  // step timer, frozen outside run so a hold keeps its place
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tick_ff <= 14'h0000;
    else if (state_ff == sseq_pkg::ST_APPLY)
      tick_ff <= 14'h0000;
    else if (state_ff == sseq_pkg::ST_RUN)
      tick_ff <= tick_last ? 14'h0000 : tick_ff + 14'h0001;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      timer_ff <= sseq_pkg::TIME_RST;
    else if (state_ff == sseq_pkg::ST_APPLY)
      timer_ff <= mem_rdata[sseq_pkg::TIME_LSB +: sseq_pkg::TIME_W];
    else if ((state_ff == sseq_pkg::ST_RUN) && tick_last && !time_done)
      timer_ff <= timer_ff - 24'h000001;
  end

  // ************************************************************
  // step memory and jump counters
  // ************************************************************
  wire mem_we = prog_we_i && (prog_addr_i != sseq_pkg::STEP_REGULAR);

  sseq_step_mem u_mem
  (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (prog_addr_i),
    .wdata_i (prog_word_i),
    .raddr_i (step_ff),
    .rdata_o (mem_rdata)
  );

  sseq_jump_ctr u_jump
  (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .sel_i     (step_ff),
    .inc_i     (jc_inc),
    .clr_i     (jc_clr),
    .clr_all_i (start_idle),
    .cnt_o     (jc_cnt)
  );

  // running step word, latched once its read data arrive
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      word_ff <= sseq_pkg::WORD_RST;
    else if (state_ff == sseq_pkg::ST_APPLY)
      word_ff <= mem_rdata;
  end

  // waveform kind is sampled once at start and kept for the sequence
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      kind_ff <= sseq_pkg::KIND_DC;
    else if (start_idle)
      kind_ff <= wave_kind_i;
  end

  // ************************************************************
  // regular output step
  // ************************************************************
  wire prog_reg = prog_we_i && (prog_addr_i == sseq_pkg::STEP_REGULAR);

  // the stop copy wins over a same-cycle programming write
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_dc_ff   <= sseq_pkg::VAL_RST;
      reg_ac_ff   <= sseq_pkg::VAL_RST;
      reg_freq_ff <= sseq_pkg::VAL_RST;
      reg_slot_ff <= sseq_pkg::SLOT_RST;
    end
    else if (go_idle)
    begin
      reg_dc_ff   <= dc_ff;
      reg_ac_ff   <= ac_ff;
      reg_freq_ff <= freq_ff;
      reg_slot_ff <= slot_ff;
    end
    else if (prog_reg)
    begin
      reg_dc_ff   <= prog_word_i[sseq_pkg::DC_LSB +: sseq_pkg::VAL_W];
      reg_ac_ff   <= prog_word_i[sseq_pkg::AC_LSB +: sseq_pkg::VAL_W];
      reg_freq_ff <= prog_word_i[sseq_pkg::FREQ_LSB +: sseq_pkg::VAL_W];
      reg_slot_ff <= prog_word_i[sseq_pkg::SLOT_LSB +: sseq_pkg::SLOT_W];
    end
  end

  // ************************************************************
  // output set values and sync code
  // ************************************************************
  // outside idle values change only on apply; hold and phase wait leave them frozen
  wire slot_free = (kind_ff == sseq_pkg::KIND_USER);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dc_ff   <= sseq_pkg::VAL_RST;
      ac_ff   <= sseq_pkg::VAL_RST;
      freq_ff <= sseq_pkg::VAL_RST;
      slot_ff <= sseq_pkg::SLOT_RST;
    end
    else if (in_idle && !start_idle)
    begin
      dc_ff   <= reg_dc_ff;
      ac_ff   <= reg_ac_ff;
      freq_ff <= reg_freq_ff;
      slot_ff <= reg_slot_ff;
    end
    else if ((state_ff == sseq_pkg::ST_APPLY) && !do_stop)
    begin
      dc_ff   <= mem_rdata[sseq_pkg::DC_LSB +: sseq_pkg::VAL_W];
      ac_ff   <= mem_rdata[sseq_pkg::AC_LSB +: sseq_pkg::VAL_W];
      freq_ff <= mem_rdata[sseq_pkg::FREQ_LSB +: sseq_pkg::VAL_W];
      if (slot_free)
        slot_ff <= mem_rdata[sseq_pkg::SLOT_LSB +: sseq_pkg::SLOT_W];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sync_ff <= sseq_pkg::SYNC_FALSE;
    else if (go_idle || in_idle)
      sync_ff <= sseq_pkg::SYNC_FALSE;
    else if (state_ff == sseq_pkg::ST_APPLY)
      sync_ff <= mem_rdata[sseq_pkg::SYNC_LSB +: sseq_pkg::SYNC_W];
  end

  // ************************************************************
  // status and outputs
  // ************************************************************
  assign status_o = in_idle ? sseq_pkg::STAT_IDLE :
                    in_hold ? sseq_pkg::STAT_HOLD : sseq_pkg::STAT_RUN;
  assign step_o               = step_ff;
  assign out_dc_o             = dc_ff;
  assign out_ac_o             = ac_ff;
  assign out_freq_o           = freq_ff;
  assign user_waveform_slot_o = slot_ff;
  assign step_sync_o          = sync_ff;

endmodule
`default_nettype wire

// *** rtl/sseq_jump_ctr.sv ***
`timescale 1ns/1ps
`default_nettype none

module sseq_jump_ctr
(
  // clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rst_b_i,
  // counter selection and updates
  input  wire logic [sseq_pkg::STEP_W-1:0]      sel_i,
  input  wire logic                             inc_i,
  input  wire logic                             clr_i,
  input  wire logic                             clr_all_i,
  output logic      [sseq_pkg::JCNT_W-1:0]      cnt_o
);

  logic [sseq_pkg::JCNT_W-1:0] cnt_ff [sseq_pkg::NUM_STEPS];

  // one independent counter per step so nested loops never share a count
  for (genvar i = 0; i < sseq_pkg::NUM_STEPS; i++)
  begin : g_ctr
    wire hit = (sel_i == sseq_pkg::STEP_W'(i));
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        cnt_ff[i] <= sseq_pkg::JCNT_RST;
      else if (clr_all_i || (hit && clr_i))
        cnt_ff[i] <= sseq_pkg::JCNT_RST;
      else if (hit && inc_i)
        cnt_ff[i] <= cnt_ff[i] + 10'h001;
    end
  end

  assign cnt_o = cnt_ff[sel_i];

endmodule
`default_nettype wire

// *** rtl/sseq_pkg.sv ***
package sseq_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int STEP_W = 8;   // step numbers 1..255, 0 is the regular step
  localparam int JCNT_W = 10;  // jump count 0..999
  localparam int SYNC_W = 2;   // step sync code
  localparam int SLOT_W = 4;   // user waveform slots 1..16 coded 0..15
  localparam int VAL_W  = 16;  // dc, ac and frequency set values
  localparam int TIME_W = 24;  // step time in 0.1 ms ticks, up to 9999999
  localparam int TERM_W = 2;
  localparam int KIND_W = 2;
  localparam int STAT_W = 2;
  localparam int NUM_STEPS = 256;

  // ************************************************************
  // step word layout
  // ************************************************************
  localparam int DC_LSB     = 0;
  localparam int AC_LSB     = 16;
  localparam int FREQ_LSB   = 32;
  localparam int SLOT_LSB   = 48;
  localparam int SYNC_LSB   = 52;
  localparam int BRANCH_LSB = 54;
  localparam int JCNT_LSB   = 62;
  localparam int JSTEP_LSB  = 72;
  localparam int TERM_LSB   = 80;
  localparam int PHASE_BIT  = 82;
  localparam int TIME_LSB   = 83;
  localparam int WORD_W     = 107;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 100000;  // step time resolution, 0.1 ms
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // ************************************************************
  // codes and reset values
  // ************************************************************
  localparam logic [TERM_W-1:0] TERM_CONTINUE_AFTER_STEP = 2'h0;
  localparam logic [TERM_W-1:0] TERM_HOLD = 2'h1;
  localparam logic [TERM_W-1:0] TERM_STOP = 2'h2;

  localparam logic [KIND_W-1:0] KIND_DC     = 2'h0;
  localparam logic [KIND_W-1:0] KIND_SINE   = 2'h1;
  localparam logic [KIND_W-1:0] KIND_SQUARE = 2'h2;
  localparam logic [KIND_W-1:0] KIND_USER   = 2'h3;

  localparam logic [STAT_W-1:0] STAT_IDLE = 2'h0;
  localparam logic [STAT_W-1:0] STAT_RUN  = 2'h1;
  localparam logic [STAT_W-1:0] STAT_HOLD = 2'h2;

  localparam logic [STEP_W-1:0] STEP_REGULAR = 8'h00;
  localparam logic [STEP_W-1:0] STEP_FIRST   = 8'h01;
  localparam logic [STEP_W-1:0] STEP_LAST    = 8'hff;
  localparam logic [STEP_W-1:0] JUMP_NEXT    = 8'h00;
  localparam logic [STEP_W-1:0] BRANCH_NONE  = 8'h00;
  localparam logic [JCNT_W-1:0] JCNT_INF     = 10'h000;
  localparam logic [JCNT_W-1:0] JCNT_RST     = 10'h000;
  localparam logic [VAL_W-1:0]  VAL_RST      = 16'h0000;
  localparam logic [SLOT_W-1:0] SLOT_RST     = 4'h0;
  localparam logic [SYNC_W-1:0] SYNC_FALSE   = 2'h0;
  localparam logic [TIME_W-1:0] TIME_RST     = 24'h000000;
  localparam logic [WORD_W-1:0] WORD_RST     = 107'h0;

  // controller states, gray along idle-load-apply-run-phase wait-hold
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOAD  = 3'h1,
    ST_APPLY = 3'h3,
    ST_RUN   = 3'h2,
    ST_PHASE = 3'h6,
    ST_HOLD  = 3'h4
  } sseq_state_t;

endpackage

// *** rtl/sseq_step_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module sseq_step_mem
(
  // clock
  input  wire logic                             clk_i,
  // write port
  input  wire logic                             we_i,
  input  wire logic [sseq_pkg::STEP_W-1:0]      waddr_i,
  input  wire logic [sseq_pkg::WORD_W-1:0]      wdata_i,
  // read port, data one cycle after the address
  input  wire logic [sseq_pkg::STEP_W-1:0]      raddr_i,
  output logic      [sseq_pkg::WORD_W-1:0]      rdata_o
);

  logic [sseq_pkg::WORD_W-1:0] mem [sseq_pkg::NUM_STEPS];

  // no reset here so the array maps onto block ram
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule
`default_nettype wire

// *** tb/sseq_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sseq_ctrl_chk
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  // controls
  input wire logic       start_i,
  input wire logic       hold_i,
  input wire logic       stop_i,
  input wire logic       prog_we_i,
  // observed outputs
  input wire logic [1:0] status_o,
  input wire logic [7:0] step_o,
  input wire logic [15:0] out_dc_o,
  input wire logic [1:0] step_sync_o
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire idle = status_o == sseq_pkg::STAT_IDLE;
  sequence s_launch;
    idle && start_i && !stop_i && !hold_i;
  endsequence
  property p_start; s_launch |=> status_o == sseq_pkg::STAT_RUN && step_o == 8'h01; endproperty
  property p_resume; status_o == sseq_pkg::STAT_HOLD && start_i && !stop_i && !hold_i
    |=> status_o == sseq_pkg::STAT_RUN; endproperty
  // hold must freeze the dc value, step number and sync code that a load would otherwise touch
  property p_hold_frz; status_o == sseq_pkg::STAT_HOLD && !start_i && !stop_i
    |=> $stable(out_dc_o) && $stable(step_o) && $stable(step_sync_o); endproperty
  property p_stop; !idle && stop_i |=> idle && step_o == 8'h00 && step_sync_o == 2'h0; endproperty
  property p_stop_copy; !idle && stop_i |=> $stable(out_dc_o); endproperty
  property p_idle_ign; idle && !start_i && !prog_we_i |=> idle && $stable(out_dc_o); endproperty
  property p_idle_sync; idle |-> step_sync_o == sseq_pkg::SYNC_FALSE; endproperty
  property p_idle_step; idle |-> step_o == sseq_pkg::STEP_REGULAR; endproperty
  a_start: assert property (p_start) else $error("start from idle wrong");
  a_resume: assert property (p_resume) else $error("resume wrong");
  a_hold_frz: assert property (p_hold_frz) else $error("hold not frozen");
  a_stop: assert property (p_stop) else $error("stop wrong");
  a_stop_copy: assert property (p_stop_copy) else $error("stop value lost");
  a_idle_ign: assert property (p_idle_ign) else $error("idle not kept");
  a_idle_sync: assert property (p_idle_sync) else $error("sync in idle");
  a_idle_step: assert property (p_idle_step) else $error("step in idle");
endmodule
bind sseq_ctrl sseq_ctrl_chk u_sseq_ctrl_chk (.*);
`default_nettype wire

// *** tb/sseq_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sseq_panel_model
(
  // clock
  input  wire logic       clk_i,
  // controls and engine status
  output logic            start_o,
  output logic            hold_o,
  output logic            stop_o,
  output logic            branch_o,
  output logic            phase_zero_o,
  output logic      [1:0] wave_kind_o
);
  logic [3:0] ph_ff;
  // waveform is chosen before any start is pressed
  initial begin
    {start_o, hold_o, stop_o, branch_o, ph_ff} = 8'h00;
    wave_kind_o = sseq_pkg::KIND_SINE;
  end
  // phase pulse every 16 cycles, off the sampling edge
  always @(negedge clk_i) begin
    ph_ff <= ph_ff + 4'h1;
    phase_zero_o <= ph_ff == 4'hf;
  end
  // waveform choice, changed off the sampling edge while idle
  task automatic pick(input logic [1:0] k);
    @(negedge clk_i);
    wave_kind_o = k;
  endtask
  // one-cycle control pulse: start, hold, stop, branch from msb
  task automatic press(input logic [3:0] m);
    @(negedge clk_i);
    {start_o, hold_o, stop_o, branch_o} = m;
    @(negedge clk_i);
    {start_o, hold_o, stop_o, branch_o} = 4'h0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rst_b_i, start_i, hold_i, stop_i, branch_i, phase_zero_i, prog_we_i;
  logic [1:0] wave_kind_i, status_o, step_sync_o;
  logic [7:0] prog_addr_i, step_o, last_step_i;
  logic [106:0] prog_word_i;
  logic [15:0] out_dc_o, out_ac_o, out_freq_o;
  logic [3:0] user_waveform_slot_o;
  int failures, check_count;
  initial begin clk_i = 0; forever #5 clk_i = ~clk_i; end
  sseq_panel_model u_sseq_panel_model (.clk_i(clk_i), .start_o(start_i), .hold_o(hold_i),
    .stop_o(stop_i), .branch_o(branch_i), .phase_zero_o(phase_zero_i), .wave_kind_o(wave_kind_i));
  // short tick keeps a step at 8 cycles
  sseq_ctrl #(.TICK_CYCLES(4)) u_sseq_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
    .hold_i(hold_i), .stop_i(stop_i), .branch_i(branch_i), .wave_kind_i(wave_kind_i),
    .last_step_i(last_step_i), .phase_zero_i(phase_zero_i), .prog_we_i(prog_we_i),
    .prog_addr_i(prog_addr_i), .prog_word_i(prog_word_i), .status_o(status_o), .step_o(step_o),
    .out_dc_o(out_dc_o), .out_ac_o(out_ac_o), .out_freq_o(out_freq_o),
    .user_waveform_slot_o(user_waveform_slot_o), .step_sync_o(step_sync_o));
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin failures++; $display("[ERR] %s exp %h got %h", nm, e, s); end
  endtask
  // bounded wait on status (st=1) or step number
  task automatic wt(bit st, logic [7:0] v);
    for (int i = 0; i < 300 && (st ? {6'h0, status_o} : step_o) !== v; i++) @(negedge clk_i);
    if ((st ? {6'h0, status_o} : step_o) !== v)
    begin failures++; $display("[ERR] wait exp %h", v); conclude(); end
  endtask
  // sync code, slot and end phase enable follow the dc value so one figure predicts them all
  task automatic wr(logic [7:0] a, logic [15:0] d, logic [7:0] br, js, logic [9:0] jc,
    logic [1:0] tm);
    @(negedge clk_i);
    prog_we_i = 1; prog_addr_i = a;
    prog_word_i = {24'h2, d[4], tm, js, jc, br, d[1:0], d[3:0], d, d, d};
    @(negedge clk_i);
    prog_we_i = 0;
  endtask
  task automatic t_ignore();
    u_sseq_panel_model.press(4'h4); u_sseq_panel_model.press(4'h1);
    chk("idle", 0, status_o); chk("dc", 0, out_dc_o);
    $display("ignore done");
  endtask
  // 1,2 looped three times, then 3 whose stop wins over its jump
  task automatic t_loop();
    int n; logic [7:0] pv;
    n = 0; pv = 0;
    u_sseq_panel_model.press(4'h8);
    repeat (300) begin @(negedge clk_i); if (step_o === 1 && pv !== 1) n++; pv = step_o; end
    chk("loops", 3, n);
    chk("status", 0, status_o); chk("dc", 3, out_dc_o);
    $display("loop done");
  endtask
  task automatic t_hold();
    u_sseq_panel_model.press(4'h8); wt(0, 2); repeat (3) @(negedge clk_i);
    chk("sync", 2, step_sync_o);
    u_sseq_panel_model.press(4'h4); chk("hold", 2, status_o);
    repeat (10) @(negedge clk_i); chk("frozen", 2, out_dc_o);
    chk("ac", 2, out_ac_o); chk("freq", 2, out_freq_o);
    chk("slot", 0, user_waveform_slot_o);
    u_sseq_panel_model.press(4'h8); chk("run", 1, status_o); chk("step", 2, step_o);
    u_sseq_panel_model.press(4'h2); chk("idle", 0, status_o);
    chk("copy", 2, out_dc_o); chk("sync0", 0, step_sync_o);
    repeat (4) @(negedge clk_i); chk("kept", 2, out_dc_o);
    $display("hold done");
  endtask
  task automatic t_branch();
    u_sseq_panel_model.press(4'h8); wt(0, 1); repeat (3) @(negedge clk_i);
    u_sseq_panel_model.press(4'h1); chk("br", 3, step_o);
    repeat (3) @(negedge clk_i);
    u_sseq_panel_model.press(4'h1); chk("br0", 3, step_o);
    wt(1, 0);
    $display("branch done");
  endtask
  task automatic t_term();
    wr(3, 3, 0, 1, 0, 2'h1);
    u_sseq_panel_model.press(4'h8); wt(1, 2); chk("step", 3, step_o);
    u_sseq_panel_model.press(4'h8); wt(0, 1); chk("run", 1, status_o);
    u_sseq_panel_model.press(4'h2);
    $display("term done");
  endtask
  // user waveform, one step with end phase that is also the last step
  task automatic t_phase();
    int n;
    u_sseq_panel_model.pick(2'h3);
    last_step_i = 1; wr(1, 16'h15, 0, 0, 0, 0);
    u_sseq_panel_model.press(4'h8); repeat (2) @(negedge clk_i);
    chk("slot", 5, user_waveform_slot_o); chk("sync", 1, step_sync_o);
    for (n = 0; n < 60 && status_o !== 0; n++) @(negedge clk_i);
    chk("idle", 0, status_o); chk("waited", 1, n > 9);
    chk("pz", 1, phase_zero_i);
    chk("end", 16'h15, out_dc_o); chk("endf", 16'h15, out_freq_o);
    $display("phase done");
  endtask
  initial begin
    rst_b_i = 0; prog_we_i = 0; prog_addr_i = 0; prog_word_i = 0; last_step_i = 3;
    repeat (6) @(negedge clk_i);
    rst_b_i = 1;
    wr(1, 1, 3, 0, 0, 0); wr(2, 2, 0, 1, 2, 0); wr(3, 3, 0, 1, 0, 2);
    t_ignore(); t_loop(); t_loop(); t_hold(); t_branch(); t_term(); t_phase();
    conclude();
  end
endmodule
`default_nettype wire
